// ==== bench/pwr_ctl_asserts.sv ====
// Checker for the power-state controller, ports of the top module only.
// Assumes one clk_sys domain; bound to the top module below.
`timescale 1ns/1ns
module pwr_ctl_asserts #(
  parameter longint DEB_CYC  = 4,
  parameter longint LONG_CYC = 60
) (
  input wire logic       clk_sys,
  input wire logic       reset,
  input wire logic       pwr_switch,
  input wire logic       usb_wake,
  input wire logic       lan_wake,
  input wire logic       rtc_alarm,
  input wire logic       pcie_wake_n,
  input wire logic       led_dual,
  input wire logic       standby_ok,
  input wire logic       psu_on,
  input wire logic [1:0] front_led,
  input wire logic       standby_led,
  input wire logic       cold_boot,
  input wire logic       resume_ram,
  input wire logic       resume_disk,
  input wire logic [2:0] power_state
);
  // ****************************************************************
  // Helper counters
  // ****************************************************************
  // Two cycles before the long event is issued, so the state is still on
  localparam int HOLD_LIM = int'(DEB_CYC + LONG_CYC) - 2;
  logic [15:0] held_reg;  // Cycles the switch has been held
  logic [15:0] idle_reg;  // Cycles since switch release
  logic        quiet;     // No LAN, PCIe or RTC wake and no pending press event
  // Press length; a late release event must not look like a wake
  always_ff @(posedge clk_sys or posedge reset)
    if (reset) held_reg <= 16'h0;
    else if (!pwr_switch) held_reg <= 16'h0;
    else if (held_reg != 16'hffff) held_reg <= held_reg + 16'h1;
  // Release age, saturating
  always_ff @(posedge clk_sys or posedge reset)
    if (reset) idle_reg <= 16'h0;
    else if (pwr_switch) idle_reg <= 16'h0;
    else if (idle_reg != 16'hffff) idle_reg <= idle_reg + 16'h1;
  assign quiet = idle_reg > 16'(DEB_CYC + 4) && !lan_wake && pcie_wake_n
                 && !rtc_alarm;
  // ****************************************************************
  // Properties
  // ****************************************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  property p_psu_off; power_state != 3'h0 |-> !psu_on; endproperty
  a_psu_off: assert property (p_psu_off)
    else $error("supply on outside working");
  property p_led;
    power_state == 3'h1 && $stable(led_dual) |-> front_led ==
      (led_dual ? pwr_seq_pkg::LED_AMBER : pwr_seq_pkg::LED_DARK);
  endproperty
  a_led: assert property (p_led) else $error("wrong sleep colour");
  property p_stby; 1'b1 |=> standby_led == $past(standby_ok); endproperty
  a_stby: assert property (p_stby) else $error("standby led");
  property p_usb;
    power_state == 3'h1 && usb_wake && quiet |-> ##[1:2] power_state == 3'h0;
  endproperty
  a_usb: assert property (p_usb) else $error("no usb wake");
  property p_ign;
    power_state inside {3'h2, 3'h3} && quiet && !$past(reset)
      |=> power_state == $past(power_state);
  endproperty
  a_ign: assert property (p_ign) else $error("woke w/o source");
  property p_cold;
    cold_boot |-> power_state == 3'h0 && $past(power_state) == 3'h3;
  endproperty
  a_cold: assert property (p_cold) else $error("cold boot pulse");
  property p_ram;
    resume_ram |-> power_state == 3'h0 && $past(power_state) == 3'h1;
  endproperty
  a_ram: assert property (p_ram) else $error("ram resume pulse");
  property p_disk;
    resume_disk |-> power_state == 3'h0 && $past(power_state) == 3'h2;
  endproperty
  a_disk: assert property (p_disk) else $error("disk resume");
  property p_pulse;
    cold_boot || resume_ram || resume_disk
      |=> !(cold_boot || resume_ram || resume_disk);
  endproperty
  a_pulse: assert property (p_pulse) else $error("pulse too long");
  property p_hold;
    held_reg == 16'(HOLD_LIM) && power_state inside {3'h0, 3'h1}
      |-> ##[0:4] power_state == 3'h3;
  endproperty
  a_hold: assert property (p_hold) else $error("no forced off");
  property p_pcie;
    power_state inside {3'h1, 3'h2} && !pcie_wake_n && !pwr_switch
      |-> ##[1:2] power_state == 3'h0;
  endproperty
  a_pcie: assert property (p_pcie) else $error("no pcie wake");
  c_cold: cover property (cold_boot);
  c_ram: cover property (resume_ram);
  c_disk: cover property (resume_disk);
endmodule // pwr_ctl_asserts

bind board_power_state_wake_control pwr_ctl_asserts #(
  .DEB_CYC(DEB_CYC), .LONG_CYC(LONG_CYC)) chk_u (.clk_sys, .reset,
  .pwr_switch, .usb_wake, .lan_wake, .rtc_alarm, .pcie_wake_n, .led_dual,
  .standby_ok, .psu_on, .front_led, .standby_led, .cold_boot, .resume_ram,
  .resume_disk, .power_state);

// ==== bench/test_board_power_state_wake_control.sv ====
// Self-checking bench for the power-state and wake controller.
// Assumes short thresholds: settle 4, short 40, long 60 cycles.
`timescale 1ns/1ns
module test_board_power_state_wake_control;
  logic clk_sys = 0, reset = 1, go = 0;
  logic os_sleep_en = 0, os_sleep_ram = 0, os_sleep_disk = 0;
  logic os_soft_off = 0, rtc_armed = 0, ac_returned = 0, last_was_on = 0;
  logic led_dual = 1, standby_ok = 1, pwr_switch, lan_wake, usb_wake;
  logic pcie_wake_n, rtc_alarm, psu_on, standby_led, cold_boot;
  logic resume_ram, resume_disk;
  logic [1:0] restore_mode = 2'h0, front_led;
  logic [2:0] kind = 3'h0, power_state, pulses;
  logic [7:0] len = 8'h0;
  int bad_count = 0, n_tests = 0;
  always #10 clk_sys = ~clk_sys;  // 50 MHz
  board_power_state_wake_control #(.DEB_CYC(4), .SHORT_CYC(40),
    .LONG_CYC(60)) dut_u (.*);
  wake_partner src_u (.*);
  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic finish_test;
    $display("Checks %0d, mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [2:0] exp, got);
    n_tests++;
    if (got !== exp)
    begin
      $display("[ERR] %s exp %h got %h", nm, exp, got);
      bad_count++;
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  // One source action from the far side
  task automatic act(input logic [2:0] k, input int l);
    @(posedge clk_sys);
    go <= 1; kind <= k; len <= 8'(l);
    @(posedge clk_sys);
    go <= 0;
  endtask
  // Bounded wait for a state; gathers pulses seen on the way
  task automatic wait_st(input logic [2:0] exp);
    int i;
    i = 0;
    pulses = 3'h0;
    while (power_state !== exp && i < 300)
    begin
      @(posedge clk_sys);
      #1 pulses = pulses | {cold_boot, resume_ram, resume_disk};
      i++;
    end
    chk("state", exp, power_state);
    if (i >= 300) finish_test();
  endtask
  task automatic do_reset(input logic ac, input logic [1:0] m,
                          input logic last);
    @(posedge clk_sys);
    reset <= 1; ac_returned <= ac; restore_mode <= m; last_was_on <= last;
    cyc(3);
    chk("rst st", 3'h3, power_state);
    chk("rst out", 3'h0, {psu_on, front_led});
    reset <= 0;
  endtask
  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_boot;
    do_reset(1'b0, 2'h0, 1'b0);
    cyc(2);
    chk("stby", 3'h1, {2'h0, standby_led});
    standby_ok <= 0;
    cyc(2);
    chk("stby off", 3'h0, {2'h0, standby_led});
    standby_ok <= 1;
    act(3'h4, 3);
    cyc(10);
    chk("unarmed", 3'h3, power_state);
    act(3'h1, 3);
    wait_st(3'h0);
    chk("cold", 3'h4, pulses);
    chk("on", {1'b1, pwr_seq_pkg::LED_GREEN}, {psu_on, front_led});
    $display("boot done");
  endtask
  task automatic t_ram;
    os_sleep_en <= 1;
    act(3'h0, 20);
    wait_st(3'h1);
    chk("amber", {1'b0, pwr_seq_pkg::LED_AMBER}, {psu_on, front_led});
    led_dual <= 0;
    cyc(3);
    chk("dark", 3'h0, {psu_on, front_led});
    led_dual <= 1;
    act(3'h2, 3);
    wait_st(3'h0);
    chk("ram res", 3'h2, pulses);
    $display("ram done");
  endtask
  task automatic t_disk;
    os_sleep_disk <= 1;
    cyc(2);
    os_sleep_disk <= 0;
    wait_st(3'h2);
    act(3'h2, 3);
    cyc(10);
    chk("usb ign", 3'h2, power_state);
    act(3'h3, 3);
    wait_st(3'h0);
    chk("disk res", 3'h1, pulses);
    $display("disk done");
  endtask
  task automatic t_long;
    os_sleep_ram <= 1;
    cyc(2);
    os_sleep_ram <= 0;
    wait_st(3'h1);
    act(3'h0, 90);
    wait_st(3'h3);
    cyc(100);
    chk("no short", 3'h3, power_state);
    rtc_armed <= 1;
    act(3'h4, 3);
    wait_st(3'h0);
    act(3'h0, 90);
    wait_st(3'h3);
    cyc(60);
    $display("long done");
  endtask
  task automatic t_ac;
    logic [1:0] md [4] = '{2'h0, 2'h1, 2'h2, 2'h2};
    logic [2:0] ex [4] = '{3'h3, 3'h0, 3'h0, 3'h3};
    for (int i = 0; i < 4; i++)
    begin
      do_reset(1'b1, md[i], i[0] ^ 1'b1);
      cyc(4);
      chk("restore", ex[i], power_state);
    end
    for (int k = 1; k < 5; k++)
    begin
      act(k[2:0], 3);
      cyc(10);
      chk("ac ign", 3'h3, power_state);
    end
    act(3'h0, 20);
    wait_st(3'h0);
    os_sleep_en <= 0;
    act(3'h0, 20);
    cyc(40);
    chk("no sleep", 3'h0, power_state);
    os_soft_off <= 1;
    cyc(2);
    os_soft_off <= 0;
    wait_st(3'h3);
    chk("off out", 3'h0, {psu_on, front_led});
    $display("ac done");
  endtask
  initial
  begin
    t_boot();
    t_ram();
    t_disk();
    t_long();
    t_ac();
    finish_test();
  end
endmodule // test_board_power_state_wake_control

// ==== bench/wake_partner.sv ====
// Model of the power switch and wake sources facing the controller.
// Assumes commands from the bench, changed at clk_sys rising edges.
`timescale 1ns/1ns
module wake_partner (
  input  wire logic       clk_sys,
  input  wire logic       go,          // Start one action
  input  wire logic [2:0] kind,        // 0 switch,1 LAN,2 USB,3 PCIe,4 RTC
  input  wire logic [7:0] len,         // Cycles the source stays active
  output logic            pwr_switch,
  output logic            lan_wake,
  output logic            usb_wake,
  output logic            pcie_wake_n,
  output logic            rtc_alarm
);
  logic [7:0] cnt_reg = 8'h0;  // Cycles left active
  logic [2:0] sel_reg = 3'h0;  // Active source
  logic       act;             // A source is asserting
  // One source at a time keeps causes apart
  always_ff @(posedge clk_sys)
    if (go)
    begin
      cnt_reg <= len;
      sel_reg <= kind;
    end
    else if (cnt_reg != 8'h0) cnt_reg <= cnt_reg - 8'h1;
  assign act         = cnt_reg != 8'h0;
  assign pwr_switch  = act && sel_reg == 3'h0;
  assign lan_wake    = act && sel_reg == 3'h1;
  assign usb_wake    = act && sel_reg == 3'h2;
  assign pcie_wake_n = !(act && sel_reg == 3'h3);
  assign rtc_alarm   = act && sel_reg == 3'h4;
endmodule // wake_partner

// ==== rtl/board_power_state_wake_control.sv ====
// Power-state and wake sequencer for the board, on standby power.
// Assumes all inputs synchronous to clk_sys; reset is the power-on reset.
//
// What this block does
// - Short press: off/sleep to work, work to sleep
// - Long hold forces soft-off from work or sleep
// - Armed clock alarm wakes from off and sleep
// - USB activity wakes from RAM sleep only
// - PCIe wake pin wakes from sleep or off
// - After AC return ignore alarm, network, PCIe wakes
// - AC return restores prior on/off per setting
// - RAM sleep: supply off, indicator amber or dark
// - Wake from RAM sleep returns to working
// - Track RAM sleep, disk sleep, soft-off apart
// - Standby indicator lit while standby power present
`timescale 1ns/1ns
module board_power_state_wake_control #(
  parameter longint DEB_CYC   = pwr_seq_pkg::DEB_CYC,   // Settle cycles
  parameter longint SHORT_CYC = pwr_seq_pkg::SHORT_CYC, // Short limit
  parameter longint LONG_CYC  = pwr_seq_pkg::LONG_CYC   // Long limit
) (
  input  wire logic       clk_sys,
  input  wire logic       reset,
  input  wire logic       pwr_switch,     // Front switch pressed, high
  input  wire logic       os_sleep_en,    // OS lets a press mean sleep
  input  wire logic       os_sleep_ram,   // OS request: enter RAM sleep
  input  wire logic       os_sleep_disk,  // OS request: enter disk sleep
  input  wire logic       os_soft_off,    // OS request: soft off
  input  wire logic       rtc_armed,      // Wake date and time programmed
  input  wire logic       rtc_alarm,      // Clock alarm match
  input  wire logic       lan_wake,       // Network wake request
  input  wire logic       usb_wake,       // USB bus activity
  input  wire logic       pcie_wake_n,    // PCIe wake pin, low active
  input  wire logic       ac_returned,    // Power-on after AC loss
  input  wire logic [1:0] restore_mode,   // Stored AC restore setting
  input  wire logic       last_was_on,    // Stored state before AC loss
  input  wire logic       led_dual,       // Front indicator is bicolour
  input  wire logic       standby_ok,     // Standby rail present
  output logic            psu_on,         // Main supply enable
  output logic [1:0]      front_led,      // Front indicator colour
  output logic            standby_led,    // Standby indicator
  output logic            cold_boot,      // Pulse: start from no context
  output logic            resume_ram,     // Pulse: resume from memory
  output logic            resume_disk,    // Pulse: resume from disk image
  output logic [2:0]      power_state     // Current state code
);

  // ****************************************************************
  // Switch timing
  // ****************************************************************
  logic short_press;                      // Short press event
  logic long_hold;                        // Long hold event

  hold_timer #(
    .CW        (32),
    .DEB_CYC   (DEB_CYC),
    .SHORT_CYC (SHORT_CYC),
    .LONG_CYC  (LONG_CYC)
  ) u_hold (
    .clk_sys     (clk_sys),
    .reset       (reset),
    .sw_raw      (pwr_switch),
    .short_press (short_press),
    .long_hold   (long_hold)
  );

  // ****************************************************************
  // AC-return window and restore
  // ****************************************************************
  pwr_seq_pkg::pwr_state_e state_reg;     // Current power state
  pwr_seq_pkg::pwr_state_e state_next;    // Next power state
  logic ac_block_reg;                     // Ignore external wakes
  logic restore_done_reg;                 // Restore decision taken
  logic restore_on;                       // Restore says power up

  // Decide once after reset whether AC return should power up
  always_comb
  begin
    case (restore_mode)
      pwr_seq_pkg::REST_ON:   restore_on = 1'b1;
      pwr_seq_pkg::REST_LAST: restore_on = (last_was_on ==
                                            pwr_seq_pkg::LAST_ON);
      default:                restore_on = 1'b0;
    endcase
  end

  // Block lasts until the system has once been working again
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
      ac_block_reg <= 1'b0;
    else if (!restore_done_reg && ac_returned)
      ac_block_reg <= 1'b1;
    else if (state_reg == pwr_seq_pkg::ST_WORK)
      ac_block_reg <= 1'b0;
  end

  // ****************************************************************
  // Wake qualification
  // ****************************************************************
  logic ext_ok;                           // External sources honoured
  logic wake_any;                         // Valid wake in this state

  assign ext_ok = !ac_block_reg;

  // Which sources count depends on the present sleep depth
  always_comb
  begin
    wake_any = 1'b0;
    case (state_reg)
      pwr_seq_pkg::ST_SLP_RAM:
        wake_any = (ext_ok && rtc_armed && rtc_alarm)
                 || (ext_ok && lan_wake)
                 || usb_wake
                 || (ext_ok && !pcie_wake_n);
      pwr_seq_pkg::ST_SLP_DISK,
      pwr_seq_pkg::ST_SOFT_OFF:
        // USB deliberately absent here
        wake_any = (ext_ok && rtc_armed && rtc_alarm)
                 || (ext_ok && lan_wake)
                 || (ext_ok && !pcie_wake_n);
      default:
        wake_any = 1'b0;
    endcase
  end

  // ****************************************************************
  // State machine
  // ****************************************************************
  // Long hold outranks every other event in work and sleep; then press, then wake
  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      pwr_seq_pkg::ST_WORK:
      begin
        if (long_hold)
          state_next = pwr_seq_pkg::ST_SOFT_OFF;
        else if (short_press && os_sleep_en)
          state_next = pwr_seq_pkg::ST_SLP_RAM;
        else if (os_soft_off)
          state_next = pwr_seq_pkg::ST_SOFT_OFF;
        else if (os_sleep_disk)
          state_next = pwr_seq_pkg::ST_SLP_DISK;
        else if (os_sleep_ram)
          state_next = pwr_seq_pkg::ST_SLP_RAM;
      end
      pwr_seq_pkg::ST_SLP_RAM,
      pwr_seq_pkg::ST_SLP_DISK:
      begin
        if (long_hold)
          state_next = pwr_seq_pkg::ST_SOFT_OFF;
        else if (short_press || wake_any)
          state_next = pwr_seq_pkg::ST_WORK;
      end
      pwr_seq_pkg::ST_SOFT_OFF:
      begin
        if (!restore_done_reg && ac_returned && restore_on)
          state_next = pwr_seq_pkg::ST_WORK;
        else if (short_press || wake_any)
          state_next = pwr_seq_pkg::ST_WORK;
      end
      default:
        state_next = pwr_seq_pkg::ST_SOFT_OFF;
    endcase
  end

  // State register; power-on reset starts in soft-off
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      state_reg        <= pwr_seq_pkg::ST_SOFT_OFF;
      restore_done_reg <= 1'b0;
    end
    else
    begin
      state_reg        <= state_next;
      restore_done_reg <= 1'b1;
    end
  end

  // ****************************************************************
  // Resume kind pulses
  // ****************************************************************
  // Exit kind tells the platform where context lives
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      cold_boot   <= 1'b0;
      resume_ram  <= 1'b0;
      resume_disk <= 1'b0;
    end
    else
    begin
      cold_boot   <= (state_reg == pwr_seq_pkg::ST_SOFT_OFF)
                  && (state_next == pwr_seq_pkg::ST_WORK);
      resume_ram  <= (state_reg == pwr_seq_pkg::ST_SLP_RAM)
                  && (state_next == pwr_seq_pkg::ST_WORK);
      resume_disk <= (state_reg == pwr_seq_pkg::ST_SLP_DISK)
                  && (state_next == pwr_seq_pkg::ST_WORK);
    end
  end

  // ****************************************************************
  // Supply and indicators
  // ****************************************************************
  // Registered from next state so outputs line up with state_reg
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      psu_on      <= 1'b0;
      front_led   <= pwr_seq_pkg::LED_DARK;
      power_state <= 3'h3;
    end
    else
    begin
      psu_on      <= (state_next == pwr_seq_pkg::ST_WORK);
      power_state <= 3'(state_next);
      case (state_next)
        pwr_seq_pkg::ST_WORK:
          front_led <= pwr_seq_pkg::LED_GREEN;
        pwr_seq_pkg::ST_SLP_RAM:
          front_led <= led_dual ? pwr_seq_pkg::LED_AMBER
                                : pwr_seq_pkg::LED_DARK;
        default:
          front_led <= pwr_seq_pkg::LED_DARK;
      endcase
    end
  end

  // Standby light follows the standby rail, not the power state
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
      standby_led <= 1'b0;
    else
      standby_led <= standby_ok;
  end

endmodule // board_power_state_wake_control

// ==== rtl/hold_timer.sv ====
// Debounce and hold timer for the front-panel power switch.
// Assumes the switch level is already synchronous to clk_sys.
`timescale 1ns/1ns
module hold_timer #(
  parameter int unsigned CW        = 32,                // Counter width
  parameter longint      DEB_CYC   = 500_000,           // Settle cycles
  parameter longint      SHORT_CYC = 200_000_000,       // Short limit
  parameter longint      LONG_CYC  = 300_000_000        // Long limit
) (
  input  wire logic clk_sys,
  input  wire logic reset,
  input  wire logic sw_raw,        // Switch pressed, high
  output logic      short_press,   // Pulse: released before short limit
  output logic      long_hold      // Pulse: held past long limit
);

  // ****************************************************************
  // Debounce
  // ****************************************************************
  logic [CW-1:0] deb_cnt_reg;      // Cycles raw differs from clean
  logic          sw_clean_reg;     // Debounced switch level
  logic [CW-1:0] hold_cnt_reg;     // Cycles held since clean press
  logic          long_done_reg;    // Long event already sent

  // Raw must hold a new level for DEB_CYC before it is believed
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      deb_cnt_reg  <= '0;
      sw_clean_reg <= 1'b0;
    end
    else if (sw_raw == sw_clean_reg)
      deb_cnt_reg <= '0;                       // Bounce restarts count
    else if (deb_cnt_reg >= CW'(DEB_CYC - 1))
    begin
      deb_cnt_reg  <= '0;
      sw_clean_reg <= sw_raw;
    end
    else
      deb_cnt_reg <= deb_cnt_reg + 1'b1;
  end

  // ****************************************************************
  // Hold timing
  // ****************************************************************
  // Count saturates so a stuck switch never wraps into a short press
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      hold_cnt_reg  <= '0;
      long_done_reg <= 1'b0;
      short_press   <= 1'b0;
      long_hold     <= 1'b0;
    end
    else
    begin
      short_press <= 1'b0;
      long_hold   <= 1'b0;
      if (sw_clean_reg)
      begin
        if (hold_cnt_reg != '1)
          hold_cnt_reg <= hold_cnt_reg + 1'b1;
        if (!long_done_reg && hold_cnt_reg >= CW'(LONG_CYC - 1))
        begin
          long_hold     <= 1'b1;
          long_done_reg <= 1'b1;
        end
      end
      else
      begin
        // Release: judge the press by its length
        if (hold_cnt_reg != '0 && hold_cnt_reg < CW'(SHORT_CYC))
          short_press <= 1'b1;
        hold_cnt_reg  <= '0;
        long_done_reg <= 1'b0;
      end
    end
  end

endmodule // hold_timer

// ==== rtl/pwr_seq_pkg.sv ====
// Constants for the board power-state and wake controller.
// Assumes a single 50 MHz standby clock feeding every module.
package pwr_seq_pkg;

  // ****************************************************************
  // Clock and timing
  // ****************************************************************
  localparam int unsigned CLK_HZ        = 50_000_000; // Standby clock rate
  localparam int unsigned SHORT_HOLD_S  = 4;          // Short press limit, s
  localparam int unsigned LONG_HOLD_S   = 6;          // Fail-safe hold, s
  localparam int unsigned DEBOUNCE_US   = 10_000;     // Switch settle, us
  // Short threshold is a longest time: rounded down
  localparam longint SHORT_CYC = longint'(SHORT_HOLD_S) * CLK_HZ;
  // Long threshold is a least time: rounded up (exact here)
  localparam longint LONG_CYC  = longint'(LONG_HOLD_S) * CLK_HZ;
  localparam longint DEB_CYC   =
    (longint'(DEBOUNCE_US) * CLK_HZ + 999_999) / 1_000_000;

  // ****************************************************************
  // Power states and saved-state encodings
  // ****************************************************************
  typedef enum logic [2:0] {
    ST_WORK,      // Working, main supply on
    ST_SLP_RAM,   // Suspend to RAM, context in memory
    ST_SLP_DISK,  // Suspend to disk, context on disk
    ST_SOFT_OFF   // Soft off, cold boot on exit
  } pwr_state_e;

  localparam logic       LAST_OFF      = 1'b0; // Saved state was off
  localparam logic       LAST_ON       = 1'b1; // Saved state was on
  localparam logic [1:0] LED_DARK      = 2'h0; // Front indicator colours
  localparam logic [1:0] LED_GREEN     = 2'h1;
  localparam logic [1:0] LED_AMBER     = 2'h2;
  localparam logic [1:0] REST_OFF      = 2'h0; // Restore policy: stay off
  localparam logic [1:0] REST_ON       = 2'h1; // Restore policy: power on
  localparam logic [1:0] REST_LAST     = 2'h2; // Restore policy: last state

endpackage
